// >>> hdl/cmf_top.sv
/*
 cmf_top: two configurable math units behind an AXI4-Lite register slave.
 assumes: sig_in and eval_tick come from logic on clk; the bus master keeps
 at most one write and one read under way.
*/
// The placing of the registers and the AXI4-Lite slave port were decided locally.
// Function
// - two independent math units, each with first and second operand
// - each operand clamped to its own limits, then weighted
// - limits and values stay within -500000 to +500000
// - weights reset to 1.0, accept -1.0 to +1.0
// - result is first operand op second operand, op selectable
// - second source zero passes conditioned first operand unchanged
// - codes 0 to 5 are eq, ne, gt, ge, lt, le
// - codes 6, 7, 8 are logical or, and, xor
// - codes 9, 10, 11 are sum, difference, product
// - logical truth is value one or more
// - comparisons and logic give exactly zero or one
// - codes 12, 13, 14 are quotient, min, max
// - zero divisor gives +500000
`default_nettype none
module cmf_top (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    // register bus
    input  wire cmf_pkg::cmf_axi_req_t axi_req,
    output var  cmf_pkg::cmf_axi_rsp_t axi_rsp,
    // signals from other blocks
    input  wire cmf_pkg::cmf_val_t     sig_in [cmf_pkg::N_SRC],
    input  wire logic                  eval_tick,
    // results to other blocks
    output var  cmf_pkg::cmf_val_t     math_res [cmf_pkg::N_UNIT],
    output var  logic                  math_done [cmf_pkg::N_UNIT]
);
    cmf_pkg::cmf_cfg_t     cfg_q [cmf_pkg::N_UNIT];
    cmf_pkg::cmf_cfg_t     cfg_d [cmf_pkg::N_UNIT];
    cmf_pkg::cmf_axi_rsp_t rsp_q;
    cmf_pkg::cmf_axi_rsp_t rsp_d;
    logic                  aw_have_q;
    logic                  aw_have_d;
    logic                  w_have_q;
    logic                  w_have_d;
    logic [31:0]           waddr_q;
    logic [31:0]           waddr_d;
    logic [31:0]           wdata_q;
    logic [31:0]           wdata_d;
    logic [3:0]            wstrb_q;
    logic [3:0]            wstrb_d;
    cmf_pkg::cmf_val_t     raw_a [cmf_pkg::N_UNIT];
    cmf_pkg::cmf_val_t     raw_b [cmf_pkg::N_UNIT];
    logic                  do_wr;
    logic                  wunit;
    logic                  runit;
    logic [31:0]           wold;

    assign axi_rsp = rsp_q;

    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{s[i]}};
        end
        return m;
    endfunction : strb_mask

    // only the two unit windows are mapped, up to the high result word
    function automatic logic addr_ok(input logic [31:0] a);
        return a[31:7] == '0 && a[5:2] <= cmf_pkg::IDX_RES_HI;
    endfunction : addr_ok

    function automatic logic [31:0] reg_view(input cmf_pkg::cmf_cfg_t c,
                                             input cmf_pkg::cmf_val_t r,
                                             input logic [3:0] idx);
        logic [31:0] v;
        v = '0;
        case (idx)
            cmf_pkg::IDX_LO_A: v = c.lo_a[31:0];
            cmf_pkg::IDX_HI_A: v = c.hi_a[31:0];
            cmf_pkg::IDX_LO_B: v = c.lo_b[31:0];
            cmf_pkg::IDX_HI_B: v = c.hi_b[31:0];
            cmf_pkg::IDX_W_A: v = 32'(signed'(c.w_a));
            cmf_pkg::IDX_W_B: v = 32'(signed'(c.w_b));
            cmf_pkg::IDX_CTRL: begin
                v[cmf_pkg::CTL_OP_LSB +: 5] = c.op;
                v[cmf_pkg::CTL_SA_LSB +: cmf_pkg::SRC_W] = c.src_a;
                v[cmf_pkg::CTL_SB_LSB +: cmf_pkg::SRC_W] = c.src_b;
            end
            cmf_pkg::IDX_RES_LO: v = r[31:0];
            cmf_pkg::IDX_RES_HI: v = 32'(signed'(r[cmf_pkg::RES_W-1:32]));
            default: v = '0;
        endcase
        return v;
    endfunction : reg_view

    // stored limits and weights are saturated so software cannot leave range
    function automatic cmf_pkg::cmf_cfg_t wr_apply(input cmf_pkg::cmf_cfg_t c,
                                                   input logic [3:0] idx,
                                                   input logic [31:0] nv);
        cmf_pkg::cmf_val_t v;
        cmf_pkg::cmf_val_t lv;
        cmf_pkg::cmf_val_t wv;
        v  = {{8{nv[31]}}, nv};
        lv = cmf_pkg::sat(v, cmf_pkg::VAL_MIN, cmf_pkg::VAL_MAX);
        wv = cmf_pkg::sat(v, cmf_pkg::WGT_MIN_V, cmf_pkg::WGT_MAX_V);
        case (idx)
            cmf_pkg::IDX_LO_A: c.lo_a = lv;
            cmf_pkg::IDX_HI_A: c.hi_a = lv;
            cmf_pkg::IDX_LO_B: c.lo_b = lv;
            cmf_pkg::IDX_HI_B: c.hi_b = lv;
            cmf_pkg::IDX_W_A: c.w_a = wv[cmf_pkg::WGT_W-1:0];
            cmf_pkg::IDX_W_B: c.w_b = wv[cmf_pkg::WGT_W-1:0];
            cmf_pkg::IDX_CTRL: begin
                c.op    = nv[cmf_pkg::CTL_OP_LSB +: 5];
                c.src_a = nv[cmf_pkg::CTL_SA_LSB +: cmf_pkg::SRC_W];
                c.src_b = nv[cmf_pkg::CTL_SB_LSB +: cmf_pkg::SRC_W];
            end
            default: c = c;
        endcase
        return c;
    endfunction : wr_apply

    function automatic cmf_pkg::cmf_cfg_t cfg_reset();
        cmf_pkg::cmf_cfg_t c;
        c.lo_a  = cmf_pkg::VAL_MIN;
        c.hi_a  = cmf_pkg::VAL_MAX;
        c.lo_b  = cmf_pkg::VAL_MIN;
        c.hi_b  = cmf_pkg::VAL_MAX;
        c.w_a   = cmf_pkg::WGT_ONE;
        c.w_b   = cmf_pkg::WGT_ONE;
        c.op    = cmf_pkg::OP_EQ;
        c.src_a = '0;
        c.src_b = '0;
        return c;
    endfunction : cfg_reset

    always_comb begin
        do_wr = aw_have_q && w_have_q;
        wunit = waddr_q[cmf_pkg::UNIT_BIT];
        runit = axi_req.araddr[cmf_pkg::UNIT_BIT];
        wold  = reg_view(cfg_q[wunit], math_res[wunit], waddr_q[5:2]);
    end

    // bus slave and configuration registers
    always_comb begin
        rsp_d     = rsp_q;
        cfg_d     = cfg_q;
        aw_have_d = aw_have_q;
        w_have_d  = w_have_q;
        waddr_d   = waddr_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        if (axi_req.awvalid && rsp_q.awready) begin
            aw_have_d = 1'b1;
            waddr_d   = axi_req.awaddr;
        end
        if (axi_req.wvalid && rsp_q.wready) begin
            w_have_d = 1'b1;
            wdata_d  = axi_req.wdata;
            wstrb_d  = axi_req.wstrb;
        end
        if (rsp_q.bvalid && axi_req.bready) begin
            rsp_d.bvalid = 1'b0;
        end
        if (do_wr) begin
            aw_have_d    = 1'b0;
            w_have_d     = 1'b0;
            rsp_d.bvalid = 1'b1;
            rsp_d.bresp  = addr_ok(waddr_q) ? cmf_pkg::RESP_OKAY : cmf_pkg::RESP_SLVERR;
            if (addr_ok(waddr_q)) begin
                cfg_d[wunit] = wr_apply(cfg_q[wunit], waddr_q[5:2],
                    (wold & ~strb_mask(wstrb_q)) | (wdata_q & strb_mask(wstrb_q)));
            end
        end
        // no new address or data until the previous response is taken
        rsp_d.awready = !aw_have_d && !rsp_d.bvalid;
        rsp_d.wready  = !w_have_d && !rsp_d.bvalid;
        if (rsp_q.rvalid && axi_req.rready) begin
            rsp_d.rvalid = 1'b0;
        end
        if (axi_req.arvalid && rsp_q.arready) begin
            rsp_d.rvalid = 1'b1;
            rsp_d.rdata  = '0;
            rsp_d.rresp  = cmf_pkg::RESP_SLVERR;
            if (addr_ok(axi_req.araddr)) begin
                rsp_d.rdata = reg_view(cfg_q[runit], math_res[runit], axi_req.araddr[5:2]);
                rsp_d.rresp = cmf_pkg::RESP_OKAY;
            end
        end
        rsp_d.arready = !rsp_d.rvalid;
        if (sys_rst) begin
            rsp_d     = '0;
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            waddr_d   = '0;
            wdata_d   = '0;
            wstrb_d   = '0;
            for (int u = 0; u < cmf_pkg::N_UNIT; u++) begin
                cfg_d[u] = cfg_reset();
            end
        end
    end

    always_ff @(posedge clk) begin
        rsp_q     <= rsp_d;
        cfg_q     <= cfg_d;
        aw_have_q <= aw_have_d;
        w_have_q  <= w_have_d;
        waddr_q   <= waddr_d;
        wdata_q   <= wdata_d;
        wstrb_q   <= wstrb_d;
    end

    // operand routing; source zero means no signal
    always_comb begin
        for (int u = 0; u < cmf_pkg::N_UNIT; u++) begin
            raw_a[u] = (cfg_q[u].src_a == '0) ? '0 : sig_in[cfg_q[u].src_a];
            raw_b[u] = (cfg_q[u].src_b == '0) ? '0 : sig_in[cfg_q[u].src_b];
        end
    end

    for (genvar g = 0; g < cmf_pkg::N_UNIT; g++) begin : g_unit
        cmf_unit u_unit (
            .clk     (clk),
            .sys_rst (sys_rst),
            .tick    (eval_tick),
            .cfg     (cfg_q[g]),
            .raw_a   (raw_a[g]),
            .raw_b   (raw_b[g]),
            .res_q   (math_res[g]),
            .done_q  (math_done[g])
        );
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_wr_unit1;
        do_wr && wunit && addr_ok(waddr_q);
    endsequence

    property p_wt_reset;
        @(posedge clk) disable iff (1'b0)
        sys_rst |=> cfg_q[0].w_a == cmf_pkg::WGT_ONE && cfg_q[1].w_b == cmf_pkg::WGT_ONE;
    endproperty
    a_wt_reset: assert property (p_wt_reset) else $error("weight not unity after reset");
    property p_lim_range;
        cfg_q[1].lo_a >= cmf_pkg::VAL_MIN && cfg_q[1].hi_b <= cmf_pkg::VAL_MAX;
    endproperty
    a_lim_range: assert property (p_lim_range) else $error("limit out of range");
    property p_indep;
        s_wr_unit1 |=> cfg_q[0] == $past(cfg_q[0]);
    endproperty
    a_indep: assert property (p_indep) else $error("unit 1 write touched unit 0");
    property p_wr_resp;
        do_wr |=> rsp_q.bvalid && !rsp_q.awready ##0 !aw_have_q;
    endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write response missing");
    property p_rd_resp;
        axi_req.arvalid && rsp_q.arready |=> rsp_q.rvalid && !rsp_q.arready;
    endproperty
    a_rd_resp: assert property (p_rd_resp) else $error("read response missing");
endmodule : cmf_top
`default_nettype wire

// >>> include/cmf_pkg.sv
/*
 cmf_pkg: constants, types and helpers shared by the math function block.
 assumes: compiled before every design file that names it.
*/
`default_nettype none
package cmf_pkg;
    localparam int N_UNIT   = 2;
    localparam int N_SRC    = 8;
    localparam int SRC_W    = 3;
    localparam int RES_W    = 40;
    localparam int WGT_W    = 17;
    localparam int WGT_FRAC = 15;
    localparam int PROD_W   = RES_W + WGT_W;

    typedef logic signed [RES_W-1:0] cmf_val_t;

    // value range and unity weight (weight is q1.15 in 17 bits)
    localparam cmf_val_t VAL_MAX   = 40'sh00_0007_A120;
    localparam cmf_val_t VAL_MIN   = 40'shFF_FFF8_5EE0;
    localparam cmf_val_t VAL_ONE   = 40'sh00_0000_0001;
    localparam cmf_val_t WGT_MAX_V = 40'sh00_0000_8000;
    localparam cmf_val_t WGT_MIN_V = 40'shFF_FFFF_8000;
    localparam logic [WGT_W-1:0] WGT_ONE = WGT_MAX_V[WGT_W-1:0];

    // operator codes
    localparam logic [4:0] OP_EQ  = 5'h00;
    localparam logic [4:0] OP_NE  = 5'h01;
    localparam logic [4:0] OP_GT  = 5'h02;
    localparam logic [4:0] OP_GE  = 5'h03;
    localparam logic [4:0] OP_LT  = 5'h04;
    localparam logic [4:0] OP_LE  = 5'h05;
    localparam logic [4:0] OP_OR  = 5'h06;
    localparam logic [4:0] OP_AND = 5'h07;
    localparam logic [4:0] OP_XOR = 5'h08;
    localparam logic [4:0] OP_ADD = 5'h09;
    localparam logic [4:0] OP_SUB = 5'h0A;
    localparam logic [4:0] OP_MUL = 5'h0B;
    localparam logic [4:0] OP_DIV = 5'h0C;
    localparam logic [4:0] OP_MIN = 5'h0D;
    localparam logic [4:0] OP_MAX = 5'h0E;

    // register map: byte address = unit * 0x40 + 4 * index
    localparam int UNIT_BIT = 6;
    localparam logic [3:0] IDX_LO_A   = 4'h0;
    localparam logic [3:0] IDX_HI_A   = 4'h1;
    localparam logic [3:0] IDX_LO_B   = 4'h2;
    localparam logic [3:0] IDX_HI_B   = 4'h3;
    localparam logic [3:0] IDX_W_A    = 4'h4;
    localparam logic [3:0] IDX_W_B    = 4'h5;
    localparam logic [3:0] IDX_CTRL   = 4'h6;
    localparam logic [3:0] IDX_RES_LO = 4'h7;
    localparam logic [3:0] IDX_RES_HI = 4'h8;
    localparam int CTL_OP_LSB = 0;
    localparam int CTL_SA_LSB = 8;
    localparam int CTL_SB_LSB = 16;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        cmf_val_t         lo_a;
        cmf_val_t         hi_a;
        cmf_val_t         lo_b;
        cmf_val_t         hi_b;
        logic [WGT_W-1:0] w_a;
        logic [WGT_W-1:0] w_b;
        logic [4:0]       op;
        logic [SRC_W-1:0] src_a;
        logic [SRC_W-1:0] src_b;
    } cmf_cfg_t;

    typedef struct packed {
        logic [31:0] awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [31:0] araddr;
        logic        arvalid;
        logic        rready;
    } cmf_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } cmf_axi_rsp_t;

    function automatic cmf_val_t sat(input cmf_val_t v, input cmf_val_t lo,
                                     input cmf_val_t hi);
        if (v < lo) begin
            return lo;
        end
        if (v > hi) begin
            return hi;
        end
        return v;
    endfunction : sat
endpackage : cmf_pkg
`default_nettype wire

// >>> hdl/cmf_unit.sv
/*
 cmf_unit: one math unit: operand clamp and weight, operator, result register.
 assumes: operands and config come from logic on clk, steady around a tick.
*/
`default_nettype none
module cmf_unit (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // evaluation request and operands
    input  wire logic              tick,
    input  wire cmf_pkg::cmf_cfg_t cfg,
    input  wire cmf_pkg::cmf_val_t raw_a,
    input  wire cmf_pkg::cmf_val_t raw_b,
    // result
    output var  cmf_pkg::cmf_val_t res_q,
    output var  logic              done_q
);
    cmf_pkg::cmf_val_t a_lim;
    cmf_pkg::cmf_val_t b_lim;
    cmf_pkg::cmf_val_t a_c;
    cmf_pkg::cmf_val_t b_c;
    cmf_pkg::cmf_val_t op_res;
    cmf_pkg::cmf_val_t res_d;
    logic              b_used;
    logic              a_t;
    logic              b_t;
    logic              done_d;

    // weight is q1.15, so full-range operand times weight stays in range
    function automatic cmf_pkg::cmf_val_t scale(input cmf_pkg::cmf_val_t v,
                                                input logic [cmf_pkg::WGT_W-1:0] w);
        logic signed [cmf_pkg::PROD_W-1:0] p;
        p = v * signed'(w);
        return p[cmf_pkg::RES_W+cmf_pkg::WGT_FRAC-1:cmf_pkg::WGT_FRAC];
    endfunction : scale

    always_comb begin
        a_lim  = cmf_pkg::sat(raw_a, cfg.lo_a, cfg.hi_a);
        b_lim  = cmf_pkg::sat(raw_b, cfg.lo_b, cfg.hi_b);
        a_c    = scale(a_lim, cfg.w_a);
        b_c    = scale(b_lim, cfg.w_b);
        b_used = cfg.src_b != '0;
        a_t    = a_c >= cmf_pkg::VAL_ONE;
        b_t    = b_c >= cmf_pkg::VAL_ONE;
    end

    always_comb begin
        op_res = '0;
        case (cfg.op)
            cmf_pkg::OP_EQ: op_res = cmf_pkg::cmf_val_t'(a_c == b_c);
            cmf_pkg::OP_NE: op_res = cmf_pkg::cmf_val_t'(a_c != b_c);
            cmf_pkg::OP_GT: op_res = cmf_pkg::cmf_val_t'(a_c > b_c);
            cmf_pkg::OP_GE: op_res = cmf_pkg::cmf_val_t'(a_c >= b_c);
            cmf_pkg::OP_LT: op_res = cmf_pkg::cmf_val_t'(a_c < b_c);
            cmf_pkg::OP_LE: op_res = cmf_pkg::cmf_val_t'(a_c <= b_c);
            cmf_pkg::OP_OR: op_res = cmf_pkg::cmf_val_t'(a_t | b_t);
            cmf_pkg::OP_AND: op_res = cmf_pkg::cmf_val_t'(a_t & b_t);
            cmf_pkg::OP_XOR: op_res = cmf_pkg::cmf_val_t'(a_t ^ b_t);
            cmf_pkg::OP_ADD: op_res = a_c + b_c;
            cmf_pkg::OP_SUB: op_res = a_c - b_c;
            cmf_pkg::OP_MUL: op_res = a_c * b_c;
            // zero divisor gives full scale rather than a trap
            cmf_pkg::OP_DIV: op_res = (b_c == '0) ? cmf_pkg::VAL_MAX : a_c / b_c;
            cmf_pkg::OP_MIN: op_res = (a_c < b_c) ? a_c : b_c;
            cmf_pkg::OP_MAX: op_res = (a_c > b_c) ? a_c : b_c;
            default: op_res = '0;
        endcase
    end

    always_comb begin
        res_d  = res_q;
        done_d = tick;
        if (tick) begin
            res_d = b_used ? op_res : a_c;
        end
        if (sys_rst) begin
            res_d  = '0;
            done_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        res_q  <= res_d;
        done_q <= done_d;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_eval(logic [4:0] code);
        tick && b_used && cfg.op == code;
    endsequence

    property p_clamp;
        cfg.lo_a <= cfg.hi_a |-> a_lim >= cfg.lo_a && a_lim <= cfg.hi_a;
    endproperty
    a_clamp: assert property (p_clamp) else $error("operand outside limits");
    property p_range;
        a_c >= cmf_pkg::VAL_MIN && a_c <= cmf_pkg::VAL_MAX;
    endproperty
    a_range: assert property (p_range) else $error("operand out of range");
    property p_unity;
        cfg.w_a == cmf_pkg::WGT_ONE |-> a_c == a_lim;
    endproperty
    a_unity: assert property (p_unity) else $error("unity weight changed value");
    property p_bypass;
        tick && !b_used |=> res_q == $past(a_c);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass not taken");
    property p_cmp;
        s_eval(cmf_pkg::OP_GT) |=> (res_q == cmf_pkg::VAL_ONE) == ($past(a_c) > $past(b_c));
    endproperty
    a_cmp: assert property (p_cmp) else $error("greater-than wrong");
    property p_logic;
        s_eval(cmf_pkg::OP_XOR) |=> (res_q == cmf_pkg::VAL_ONE)
            == (($past(a_c) >= cmf_pkg::VAL_ONE) != ($past(b_c) >= cmf_pkg::VAL_ONE));
    endproperty
    a_logic: assert property (p_logic) else $error("xor wrong");
    property p_bool;
        tick && b_used && cfg.op <= cmf_pkg::OP_XOR |=> res_q == '0 || res_q == cmf_pkg::VAL_ONE;
    endproperty
    a_bool: assert property (p_bool) else $error("logic result not 0 or 1");
    property p_sub;
        s_eval(cmf_pkg::OP_SUB) |=> res_q == $past(a_c) - $past(b_c);
    endproperty
    a_sub: assert property (p_sub) else $error("difference wrong");
    property p_max;
        s_eval(cmf_pkg::OP_MAX) |=> res_q >= $past(a_c) && res_q >= $past(b_c);
    endproperty
    a_max: assert property (p_max) else $error("max wrong");
    property p_div0;
        s_eval(cmf_pkg::OP_DIV) ##0 b_c == '0 |=> res_q == cmf_pkg::VAL_MAX;
    endproperty
    a_div0: assert property (p_div0) else $error("zero divisor not full scale");
    property p_hold;
        !tick |=> $stable(res_q) && !done_q;
    endproperty
    a_hold: assert property (p_hold) else $error("result moved without tick");
    property p_bad;
        tick && b_used && cfg.op > cmf_pkg::OP_MAX |=> res_q == '0;
    endproperty
    a_bad: assert property (p_bad) else $error("unknown operator not zero");
endmodule : cmf_unit
`default_nettype wire

// >>> dv/cmf_src_model.sv
/*
 cmf_src_model: stand-in for the blocks that feed sig_in, one held value per source.
 assumes: the bench loads at most one source a cycle, on clk.
*/
`default_nettype none
module cmf_src_model (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // load port from the bench
    input  wire logic              ld,
    input  wire logic [2:0]        ld_idx,
    input  wire cmf_pkg::cmf_val_t ld_val,
    // signals to the block
    output var  cmf_pkg::cmf_val_t sig [cmf_pkg::N_SRC]
);
    timeunit 1ns;
    timeprecision 1ps;
    // source 0 means no source: held at zero so a stray select reads nothing
    always_ff @(posedge clk) begin
        for (int i = 0; i < cmf_pkg::N_SRC; i++) begin
            if (sys_rst || i == 0) sig[i] <= '0;
            else if (ld && ld_idx == i[2:0]) sig[i] <= ld_val;
        end
    end
endmodule : cmf_src_model
`default_nettype wire

// >>> dv/configurable_math_function_block_test.sv
/*
 bench for cmf_top: register access, reset values, every operator code on both units.
 assumes: cmf_src_model supplies sig_in; expected results kept in one queue per unit.
*/
`default_nettype none
module configurable_math_function_block_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  clk = 1'b0;
    logic                  sys_rst = 1'b1;
    cmf_pkg::cmf_axi_req_t axi_req = '0;
    cmf_pkg::cmf_axi_rsp_t axi_rsp;
    cmf_pkg::cmf_val_t     sig_in [cmf_pkg::N_SRC];
    cmf_pkg::cmf_val_t     math_res [cmf_pkg::N_UNIT];
    logic                  math_done [cmf_pkg::N_UNIT];
    logic                  eval_tick = 1'b0;
    logic                  ld = 1'b0;
    logic [2:0]            ld_idx = '0;
    cmf_pkg::cmf_val_t     ld_val = '0;
    cmf_pkg::cmf_val_t     expq [2][$];
    cmf_pkg::cmf_val_t     e [2];
    int                    err_total = 0;
    int                    checks = 0;
    int                    cyc = 0;
    longint                lo [2][2], hi [2][2], wt [2][2], sv [8];
    logic [4:0]            opc [2];
    logic [2:0]            sa [2], sb [2];
    logic [31:0]           rv [7] = '{32'hFFF85EE0, 32'h0007A120, 32'hFFF85EE0,
                                      32'h0007A120, 32'h00008000, 32'h00008000, 32'h00000000};

    cmf_top uut (.clk(clk), .sys_rst(sys_rst), .axi_req(axi_req), .axi_rsp(axi_rsp),
        .sig_in(sig_in), .eval_tick(eval_tick), .math_res(math_res), .math_done(math_done));
    cmf_src_model src (.clk(clk), .sys_rst(sys_rst), .ld(ld), .ld_idx(ld_idx),
        .ld_val(ld_val), .sig(sig_in));

    always #2.5 clk = ~clk;

    task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s exp=%h seen=%h", nm, exp, seen);
        end
    endtask : chk

    task automatic wrap_up();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    // hang guard: the whole run needs about 4.5k cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            wrap_up();
        end
    end

    // each channel released only at the edge that takes it
    task automatic wr(input int u, input int idx, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        axi_req.awaddr <= 32'(u * 64 + idx * 4);
        axi_req.wdata <= d;
        axi_req.wstrb <= 4'hF;
        axi_req.awvalid <= 1'b1;
        axi_req.wvalid <= 1'b1;
        axi_req.bready <= 1'b1;
        do begin
            @(posedge clk);
            if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
            if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
        end while (axi_rsp.bvalid !== 1'b1);
        axi_req.bready <= 1'b0;
        chk("bresp", axi_rsp.bresp, er);
    endtask : wr

    task automatic rd(input int u, input int idx, input logic [31:0] ed, input logic [1:0] er);
        @(posedge clk);
        axi_req.araddr <= 32'(u * 64 + idx * 4);
        axi_req.arvalid <= 1'b1;
        axi_req.rready <= 1'b1;
        do begin
            @(posedge clk);
            if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
        end while (axi_rsp.rvalid !== 1'b1);
        axi_req.rready <= 1'b0;
        chk("rdata", axi_rsp.rdata, ed);
        chk("rresp", axi_rsp.rresp, er);
    endtask : rd

    // clamp then weight; q1.15 product floors
    function automatic longint cnd(input int u, input int k);
        longint v;
        v = sv[k ? sb[u] : sa[u]];
        v = v < lo[u][k] ? lo[u][k] : (v > hi[u][k] ? hi[u][k] : v);
        return (v * wt[u][k]) >>> 15;
    endfunction : cnd

    function automatic longint res(input int u);
        longint a, b;
        a = cnd(u, 0);
        b = cnd(u, 1);
        if (sb[u] == 0) return a;
        case (opc[u])
            0: return a == b;
            1: return a != b;
            2: return a > b;
            3: return a >= b;
            4: return a < b;
            5: return a <= b;
            6: return (a >= 1) || (b >= 1);
            7: return (a >= 1) && (b >= 1);
            8: return (a >= 1) ^ (b >= 1);
            9: return a + b;
            10: return a - b;
            11: return a * b;
            12: return b == 0 ? 500000 : a / b;
            13: return a < b ? a : b;
            14: return a > b ? a : b;
            default: return 0;
        endcase
    endfunction : res

    // results land one cycle after the tick, oldest note first
    always @(posedge clk) begin
        for (int k = 0; k < 2; k++) begin
            if (math_done[k] === 1'b1) begin
                if (expq[k].size() == 0) chk("spare done", 1'b1, 1'b0);
                else chk("math_res", math_res[k], expq[k].pop_front());
            end
        end
    end

    initial begin
        int u, i, r, mag;
        void'($urandom(32'hfa416b34));
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        for (u = 0; u < 2; u++) begin
            for (i = 0; i < 7; i++) rd(u, i, rv[i], cmf_pkg::RESP_OKAY);
        end
        wr(0, 7, 32'h00001234, cmf_pkg::RESP_OKAY);
        rd(0, 7, 32'h00000000, cmf_pkg::RESP_OKAY);
        rd(0, 9, 32'h00000000, cmf_pkg::RESP_SLVERR);
        wr(2, 0, 32'h00000005, cmf_pkg::RESP_SLVERR);
        wr(1, 1, 32'h000F4240, cmf_pkg::RESP_OKAY);
        rd(1, 1, 32'h0007A120, cmf_pkg::RESP_OKAY);
        wr(1, 5, 32'h00010000, cmf_pkg::RESP_OKAY);
        rd(1, 5, 32'h00008000, cmf_pkg::RESP_OKAY);
        for (r = 0; r < 64; r++) begin
            mag = (r % 2) ? 3 : 600000;
            for (i = 1; i < 8; i++) sv[i] = longint'($urandom_range(2 * mag)) - mag;
            for (u = 0; u < 2; u++) begin
                opc[u] = 5'((r + 7 * u) % 16);
                sa[u] = 3'($urandom_range(7));
                sb[u] = (r % 5 == 0) ? 3'h0 : 3'($urandom_range(7, 1));
                for (i = 0; i < 2; i++) begin
                    lo[u][i] = -longint'($urandom_range(500000));
                    hi[u][i] = longint'($urandom_range(500000));
                    wt[u][i] = (r % 4 == 0) ? 32768 : longint'($urandom_range(65536)) - 32768;
                    wr(u, 2 * i, 32'(lo[u][i]), cmf_pkg::RESP_OKAY);
                    wr(u, 2 * i + 1, 32'(hi[u][i]), cmf_pkg::RESP_OKAY);
                    wr(u, 4 + i, 32'(wt[u][i]), cmf_pkg::RESP_OKAY);
                end
                wr(u, 6, {13'h0, sb[u], 5'h0, sa[u], 3'h0, opc[u]}, cmf_pkg::RESP_OKAY);
            end
            // zero divisor on a divide
            if (r == 44) sv[sb[0]] = 0;
            for (i = 1; i < 8; i++) begin
                @(posedge clk);
                ld <= 1'b1;
                ld_idx <= 3'(i);
                ld_val <= 40'(sv[i]);
            end
            @(posedge clk);
            ld <= 1'b0;
            eval_tick <= 1'b1;
            // every third round the tick is held, giving back-to-back evaluations
            repeat (1 + (r % 3 == 0)) begin
                for (u = 0; u < 2; u++) begin
                    e[u] = 40'(res(u));
                    expq[u].push_back(e[u]);
                end
                @(posedge clk);
            end
            eval_tick <= 1'b0;
            rd(r % 2, 7, e[r % 2][31:0], cmf_pkg::RESP_OKAY);
        end
        repeat (4) @(posedge clk);
        // mid-run reset: weight and result must return to their reset values
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rd(1, 5, 32'h00008000, cmf_pkg::RESP_OKAY);
        rd(0, 7, 32'h00000000, cmf_pkg::RESP_OKAY);
        chk("queue left", 40'(expq[0].size() + expq[1].size()), 40'h0);
        wrap_up();
    end
endmodule : configurable_math_function_block_test
`default_nettype wire
